// ### rtl/pfs_flags.sv
// Local design decisions: strobed register access and the register addresses.
`timescale 1ns/1ps
// Contract
// - current-limit flag reads 1 while regulator current limit is engaged, else 0
// - link flag sets when a chip-select frame ends on a zero or non-multiple-of-16 clock count
// - link flag sets when the write check code mismatches the computed code
// - link flag holds until a valid command, then a secondary status read
// - internal rail flag sets on any primary rail over- or under-voltage
module pfs_flags
    import pfs_pkg::*;
#(
    parameter int unsigned NUM_RAILS = 4
) (
    input wire logic clk_sys_in,
    input wire logic rstn_in,
    input wire logic [pfs_pkg::ADDR_W-1:0] reg_addr_in,
    input wire logic [pfs_pkg::DATA_W-1:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [pfs_pkg::DATA_W-1:0] reg_rdata_out,
    input wire logic link_sclk_in,
    input wire logic link_cs_n_in,
    input wire logic link_mosi_in,
    input wire logic ilimit_active_in,
    input wire logic [NUM_RAILS-1:0] rail_ov_in,
    input wire logic [NUM_RAILS-1:0] rail_uv_in,
    input wire logic shoot_through_in,
    output logic [pfs_pkg::NUM_FLAGS-1:0] fault_flags_out,
    output logic irq_out
);
    import pfs_pkg::*;

    if (NUM_RAILS < 1) begin : g_chk_rails
        $error("NUM_RAILS must be at least 1");
    end
    if (NUM_FLAGS != 4) begin : g_chk_flags
        $error("flag layout holds exactly four flags");
    end
    if (WORD_BITS != 16) begin : g_chk_word
        $error("length check assumes sixteen-bit words");
    end
    if ((1 << CNT_W) <= WRITE_FRAME_BITS) begin : g_chk_cnt
        $error("bit counter too narrow for a write frame");
    end
    if (DATA_W < NUM_FLAGS) begin : g_chk_data
        $error("register word narrower than the flag set");
    end
    if (ADDR_W < 4) begin : g_chk_addr
        $error("register address too narrow for the offsets");
    end

    // reset release
    logic rst_s1_r;
    logic rstn_r;
    always_ff @(posedge clk_sys_in or negedge rstn_in) begin
        if (!rstn_in) begin
            rst_s1_r <= 1'b0;
            rstn_r <= 1'b0;
        end else begin
            rst_s1_r <= 1'b1;
            rstn_r <= rst_s1_r;
        end
    end

    // input synchronisers
    localparam int unsigned SYN_W = 4 + 2 * NUM_RAILS;
    logic [SYN_W-1:0] syn1_r;
    logic [SYN_W-1:0] syn2_r;
    always_ff @(posedge clk_sys_in or negedge rstn_r) begin
        if (!rstn_r) begin
            syn1_r <= {{(SYN_W-2){1'b0}}, 2'b10};
            syn2_r <= {{(SYN_W-2){1'b0}}, 2'b10};
        end else begin
            syn1_r <= {rail_uv_in, rail_ov_in, shoot_through_in, ilimit_active_in,
                       link_cs_n_in, link_sclk_in};
            syn2_r <= syn1_r;
        end
    end

    logic sclk_s;
    logic cs_n_s;
    logic mosi_s;
    logic ilim_s;
    logic shoot_s;
    logic rail_any_s;
    assign sclk_s = syn2_r[0];
    assign cs_n_s = syn2_r[1];
    assign ilim_s = syn2_r[2];
    assign shoot_s = syn2_r[3];
    assign rail_any_s = |syn2_r[SYN_W-1:4];

    logic mosi1_r;
    logic mosi2_r;
    always_ff @(posedge clk_sys_in or negedge rstn_r) begin
        if (!rstn_r) begin
            mosi1_r <= 1'b0;
            mosi2_r <= 1'b0;
        end else begin
            mosi1_r <= link_mosi_in;
            mosi2_r <= mosi1_r;
        end
    end
    assign mosi_s = mosi2_r;

    // link edge detection
    logic sclk_prev_r;
    logic cs_n_prev_r;
    always_ff @(posedge clk_sys_in or negedge rstn_r) begin
        if (!rstn_r) begin
            sclk_prev_r <= 1'b0;
            cs_n_prev_r <= 1'b1;
        end else begin
            sclk_prev_r <= sclk_s;
            cs_n_prev_r <= cs_n_s;
        end
    end

    logic bit_take;
    logic frame_start;
    logic frame_end;
    assign bit_take = !cs_n_s && sclk_s && !sclk_prev_r;
    assign frame_start = !cs_n_s && cs_n_prev_r;
    assign frame_end = cs_n_s && !cs_n_prev_r;

    // frame receiver: bit count, command word, check code
    logic [CNT_W-1:0] cnt_r;
    logic [WORD_BITS-1:0] shift_r;
    logic [WORD_BITS-1:0] cmd_r;
    logic [7:0] crc_r;
    logic [7:0] crc_nxt;
    logic crc_fb;

    assign crc_fb = crc_r[7] ^ mosi_s;
    assign crc_nxt = {crc_r[6:0], 1'b0} ^ (crc_fb ? CRC_POLY : 8'h00);

    always_ff @(posedge clk_sys_in or negedge rstn_r) begin
        if (!rstn_r) begin
            cnt_r <= '0;
            shift_r <= '0;
            cmd_r <= '0;
            crc_r <= CRC_INIT;
        end else if (frame_start) begin
            cnt_r <= '0;
            crc_r <= CRC_INIT;
        end else if (bit_take) begin
            if (cnt_r != {CNT_W{1'b1}}) begin
                cnt_r <= cnt_r + 1'b1;
            end
            shift_r <= {shift_r[WORD_BITS-2:0], mosi_s};
            if (cnt_r < CNT_W'(WORD_BITS)) begin
                crc_r <= crc_nxt;
            end
            if (cnt_r == CNT_W'(WORD_BITS - 1)) begin
                cmd_r <= {shift_r[WORD_BITS-2:0], mosi_s};
            end
        end
    end

    // frame judgement at chip-select release
    logic len_ok;
    logic is_write;
    logic crc_ok;
    logic frame_ok;
    logic frame_bad;
    logic sec_read;
    assign len_ok = (cnt_r[3:0] == 4'h0) && (cnt_r != '0);
    assign is_write = cmd_r[CMD_WRITE_BIT];
    assign crc_ok = (cnt_r == CNT_W'(WRITE_FRAME_BITS)) && (shift_r[7:0] == crc_r);
    assign frame_ok = len_ok && (!is_write || crc_ok);
    assign frame_bad = frame_end && !frame_ok;
    assign sec_read = !is_write && (cmd_r[CMD_ADDR_HI:CMD_ADDR_LO] == SEC_STATUS_ADDR);

    // link fault flag with two-step clearing
    typedef enum logic [2:0] {
        LNK_CLEAN = 3'h1,
        LNK_FAULT = 3'h2,
        LNK_ARMED = 3'h4
    } pfs_link_state_t;
    pfs_link_state_t link_state_r;
    logic link_flag;
    assign link_flag = (link_state_r != LNK_CLEAN);
    always_ff @(posedge clk_sys_in or negedge rstn_r) begin
        if (!rstn_r) begin
            link_state_r <= LNK_CLEAN;
        end else if (frame_end) begin
            case (link_state_r)
                LNK_CLEAN: begin
                    if (frame_bad) begin
                        link_state_r <= LNK_FAULT;
                    end
                end
                LNK_FAULT: begin
                    if (!frame_bad) begin
                        link_state_r <= LNK_ARMED;
                    end
                end
                LNK_ARMED: begin
                    if (frame_bad) begin
                        link_state_r <= LNK_FAULT;
                    end else if (sec_read) begin
                        link_state_r <= LNK_CLEAN;
                    end
                end
                default: begin
                    link_state_r <= LNK_FAULT;
                end
            endcase
        end
    end

    // fault flags, no software write path
    logic [NUM_FLAGS-1:0] flags_nxt;
    always_comb begin
        flags_nxt = RST_FLAGS;
        flags_nxt[BIT_RAIL] = rail_any_s;
        flags_nxt[BIT_LINK] = link_flag;
        flags_nxt[BIT_ILIM] = ilim_s;
        flags_nxt[BIT_SHOOT] = shoot_s;
    end

    logic [NUM_FLAGS-1:0] flags_r;
    always_ff @(posedge clk_sys_in or negedge rstn_r) begin
        if (!rstn_r) begin
            flags_r <= RST_FLAGS;
        end else begin
            flags_r <= flags_nxt;
        end
    end
    assign fault_flags_out = flags_r;

    // interrupt status, clear and enable
    logic wr_clear;
    logic wr_enable;
    assign wr_clear = reg_wr_in && (reg_addr_in == OFS_INT_CLEAR);
    assign wr_enable = reg_wr_in && (reg_addr_in == OFS_INT_ENABLE);

    logic [NUM_FLAGS-1:0] flags_prev_r;
    logic [NUM_FLAGS-1:0] int_status_r;
    logic [NUM_FLAGS-1:0] int_enable_r;
    logic [NUM_FLAGS-1:0] rise;
    assign rise = flags_r & ~flags_prev_r;

    always_ff @(posedge clk_sys_in or negedge rstn_r) begin
        if (!rstn_r) begin
            flags_prev_r <= RST_FLAGS;
        end else begin
            flags_prev_r <= flags_r;
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < NUM_FLAGS; gi++) begin : g_int
            always_ff @(posedge clk_sys_in or negedge rstn_r) begin
                if (!rstn_r) begin
                    int_status_r[gi] <= 1'b0;
                end else if (rise[gi]) begin
                    int_status_r[gi] <= 1'b1;
                end else if (wr_clear && reg_wdata_in[gi]) begin
                    int_status_r[gi] <= 1'b0;
                end
            end
        end
    endgenerate

    always_ff @(posedge clk_sys_in or negedge rstn_r) begin
        if (!rstn_r) begin
            int_enable_r <= RST_INT_ENABLE;
        end else if (wr_enable) begin
            int_enable_r <= reg_wdata_in[NUM_FLAGS-1:0];
        end
    end

    always_ff @(posedge clk_sys_in or negedge rstn_r) begin
        if (!rstn_r) begin
            irq_out <= 1'b0;
        end else begin
            irq_out <= |(int_status_r & int_enable_r);
        end
    end

    // register read port, data one cycle after the strobe
    logic [DATA_W-1:0] rdata_nxt;
    always_comb begin
        rdata_nxt = '0;
        if (reg_addr_in == OFS_FAULT) begin
            rdata_nxt[NUM_FLAGS-1:0] = flags_r;
        end else if (reg_addr_in == OFS_INT_STATUS) begin
            rdata_nxt[NUM_FLAGS-1:0] = int_status_r;
        end else if (reg_addr_in == OFS_INT_ENABLE) begin
            rdata_nxt[NUM_FLAGS-1:0] = int_enable_r;
        end
    end

    always_ff @(posedge clk_sys_in or negedge rstn_r) begin
        if (!rstn_r) begin
            reg_rdata_out <= '0;
        end else if (reg_rd_in) begin
            reg_rdata_out <= rdata_nxt;
        end else begin
            reg_rdata_out <= '0;
        end
    end
endmodule

// ### rtl/pfs_pkg.sv
package pfs_pkg;
    // register port
    localparam int unsigned ADDR_W = 4;
    localparam int unsigned DATA_W = 32;
    localparam logic [3:0] OFS_FAULT = 4'h0;
    localparam logic [3:0] OFS_INT_STATUS = 4'h4;
    localparam logic [3:0] OFS_INT_CLEAR = 4'h8;
    localparam logic [3:0] OFS_INT_ENABLE = 4'hC;
    // fault flag field positions
    localparam int unsigned BIT_RAIL = 0;
    localparam int unsigned BIT_LINK = 1;
    localparam int unsigned BIT_ILIM = 2;
    localparam int unsigned BIT_SHOOT = 3;
    localparam int unsigned NUM_FLAGS = 4;
    localparam logic [3:0] RST_FLAGS = 4'h0;
    localparam logic [3:0] RST_INT_ENABLE = 4'h0;
    // serial frame layout
    localparam int unsigned WORD_BITS = 16;
    localparam int unsigned WRITE_FRAME_BITS = 32;
    localparam int unsigned CMD_WRITE_BIT = 15;
    localparam int unsigned CMD_ADDR_HI = 14;
    localparam int unsigned CMD_ADDR_LO = 8;
    localparam logic [6:0] SEC_STATUS_ADDR = 7'h05;
    localparam logic [7:0] CRC_POLY = 8'h07;
    localparam logic [7:0] CRC_INIT = 8'hFF;
    localparam int unsigned CNT_W = 8;
endpackage

// ### dv/pfs_flags_asserts.sv
`timescale 1ns/1ps
module pfs_flags_asserts
    import pfs_pkg::*;
#(
    parameter int unsigned NUM_RAILS = 4
) (
    input wire logic clk_sys_in,
    input wire logic rstn_in,
    input wire logic [pfs_pkg::ADDR_W-1:0] reg_addr_in,
    input wire logic [pfs_pkg::DATA_W-1:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    input wire logic [pfs_pkg::DATA_W-1:0] reg_rdata_out,
    input wire logic link_sclk_in,
    input wire logic link_cs_n_in,
    input wire logic link_mosi_in,
    input wire logic ilimit_active_in,
    input wire logic [NUM_RAILS-1:0] rail_ov_in,
    input wire logic [NUM_RAILS-1:0] rail_uv_in,
    input wire logic shoot_through_in,
    input wire logic [pfs_pkg::NUM_FLAGS-1:0] fault_flags_out,
    input wire logic irq_out
);
    logic [3:0] up_cnt_r;
    logic up;
    assign up = up_cnt_r[3];
    always_ff @(posedge clk_sys_in or negedge rstn_in) begin
        if (!rstn_in) begin
            up_cnt_r <= 4'h0;
        end else if (!up) begin
            up_cnt_r <= up_cnt_r + 4'h1;
        end
    end
    default clocking @(posedge clk_sys_in); endclocking
    default disable iff (!rstn_in);
    property p_ilim;
        (up && $stable(ilimit_active_in)) [*4] |-> fault_flags_out[BIT_ILIM] == ilimit_active_in;
    endproperty
    a_ilim: assert property (p_ilim) else $error("current limit flag wrong");
    property p_rail;
        (up && $stable(rail_ov_in) && $stable(rail_uv_in)) [*4]
            |-> fault_flags_out[BIT_RAIL] == |(rail_ov_in | rail_uv_in);
    endproperty
    a_rail: assert property (p_rail) else $error("rail flag wrong");
    property p_shoot;
        (up && $stable(shoot_through_in)) [*4] |-> fault_flags_out[BIT_SHOOT] == shoot_through_in;
    endproperty
    a_shoot: assert property (p_shoot) else $error("shoot-through flag wrong");
    property p_rd_idle;
        !$past(reg_rd_in) |-> reg_rdata_out == 32'h0000_0000;
    endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data outside read slot");
    property p_rd_fault;
        $past(reg_rd_in && reg_addr_in == OFS_FAULT) |-> reg_rdata_out == 32'($past(fault_flags_out));
    endproperty
    a_rd_fault: assert property (p_rd_fault) else $error("flag read mismatch");
    property p_rd_clear;
        $past(reg_rd_in && reg_addr_in == OFS_INT_CLEAR) |-> reg_rdata_out == 32'h0000_0000;
    endproperty
    a_rd_clear: assert property (p_rd_clear) else $error("clear register not zero");
    property p_link_quiet;
        (up && link_cs_n_in) [*8] |=> $stable(fault_flags_out[BIT_LINK]);
    endproperty
    a_link_quiet: assert property (p_link_quiet) else $error("link flag moved idle");
    property p_irq_off;
        reg_wr_in && reg_addr_in == OFS_INT_ENABLE && reg_wdata_in[3:0] == 4'h0 |-> ##2 !irq_out;
    endproperty
    a_irq_off: assert property (p_irq_off) else $error("irq high while masked");
endmodule

// ### dv/pfs_host.sv
`timescale 1ns/1ps
module pfs_host (
    output logic sclk_out,
    output logic cs_n_out,
    output logic mosi_out
);
    initial begin
        sclk_out = 1'b0;
        cs_n_out = 1'b1;
        mosi_out = 1'b0;
    end
    // sends the low n bits of d msb first, serial clock idles low between frames
    task automatic frame(input logic [31:0] d, input int n);
        #167 cs_n_out = 1'b0;
        for (int i = n - 1; i >= 0; i--) begin
            mosi_out = d[i];
            #160 sclk_out = 1'b1;
            #160 sclk_out = 1'b0;
        end
        mosi_out = ~mosi_out;
        #160 cs_n_out = 1'b1;
        #400;
    endtask
endmodule

// ### dv/test_pfs_flags.sv
`timescale 1ns/1ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin mismatches++; \
    $display("Error %0t: got %h exp %h", $time, g, e); end end
module test_pfs_flags;
    import pfs_pkg::*;
    logic clk_sys_in, rstn_in, reg_wr_in, reg_rd_in, ilimit_active_in, shoot_through_in;
    logic link_sclk_in, link_cs_n_in, link_mosi_in, irq_out;
    logic [3:0] reg_addr_in, rail_ov_in, rail_uv_in, fault_flags_out;
    logic [31:0] reg_wdata_in, reg_rdata_out;
    int mismatches = 0;
    int compares = 0;
    pfs_host host (.sclk_out(link_sclk_in), .cs_n_out(link_cs_n_in), .mosi_out(link_mosi_in));
    pfs_flags #(.NUM_RAILS(4)) dut (.clk_sys_in, .rstn_in, .reg_addr_in, .reg_wdata_in,
        .reg_wr_in, .reg_rd_in, .reg_rdata_out, .link_sclk_in, .link_cs_n_in, .link_mosi_in,
        .ilimit_active_in, .rail_ov_in, .rail_uv_in, .shoot_through_in, .fault_flags_out,
        .irq_out);
    initial begin
        clk_sys_in = 1'b0;
        forever #20 clk_sys_in = ~clk_sys_in;
    end
    task automatic wt();
        repeat (6) @(posedge clk_sys_in);
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk_sys_in);
        reg_addr_in <= a;
        reg_wdata_in <= d;
        reg_wr_in <= 1'b1;
        @(posedge clk_sys_in);
        reg_wr_in <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [31:0] e);
        @(posedge clk_sys_in);
        reg_addr_in <= a;
        reg_rd_in <= 1'b1;
        @(posedge clk_sys_in);
        reg_rd_in <= 1'b0;
        @(negedge clk_sys_in);
        `CHK(reg_rdata_out, e)
        @(posedge clk_sys_in);
    endtask
    function automatic logic [7:0] crc8(input logic [15:0] w);
        logic [7:0] c;
        c = CRC_INIT;
        for (int i = 15; i >= 0; i--) c = {c[6:0], 1'b0} ^ ((c[7] ^ w[i]) ? CRC_POLY : 8'h00);
        return c;
    endfunction
    task automatic give_verdict();
        $display("mismatches %0d compares %0d", mismatches, compares);
        if (mismatches == 0 && compares > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    initial begin
        {rstn_in, reg_wr_in, reg_rd_in, ilimit_active_in, shoot_through_in} = 5'h00;
        {reg_addr_in, rail_ov_in, rail_uv_in, reg_wdata_in} = 44'h000_0000_0000;
        repeat (5) @(posedge clk_sys_in);
        rstn_in <= 1'b1;
        wt();
        rd(OFS_FAULT, 32'h0000_0000);
        rd(OFS_INT_ENABLE, 32'h0000_0000);
        ilimit_active_in <= 1'b1;
        wt();
        rd(OFS_FAULT, 32'h0000_0004);
        wr(OFS_FAULT, 32'h0000_0000);
        rd(OFS_FAULT, 32'h0000_0004);
        `CHK(irq_out, 1'b0)
        wr(OFS_INT_STATUS, 32'h0000_0000);
        rd(OFS_INT_STATUS, 32'h0000_0004);
        wr(OFS_INT_ENABLE, 32'h0000_0004);
        wt();
        `CHK(irq_out, 1'b1)
        wr(OFS_INT_CLEAR, 32'h0000_0004);
        wt();
        `CHK(irq_out, 1'b0)
        rd(OFS_INT_CLEAR, 32'h0000_0000);
        rd(4'h2, 32'h0000_0000);
        wr(OFS_INT_ENABLE, 32'h0000_0000);
        ilimit_active_in <= 1'b0;
        wt();
        rd(OFS_FAULT, 32'h0000_0000);
        for (int k = 0; k < 9; k++) begin
            rail_ov_in <= (k < 4) ? 4'h1 << k : 4'h0;
            rail_uv_in <= (k >= 4 && k < 8) ? 4'h1 << (k - 4) : 4'h0;
            wt();
            rd(OFS_FAULT, (k < 8) ? 32'h0000_0001 : 32'h0000_0000);
        end
        shoot_through_in <= 1'b1;
        wt();
        rd(OFS_FAULT, 32'h0000_0008);
        shoot_through_in <= 1'b0;
        host.frame(32'h0000_0500, 16);
        rd(OFS_FAULT, 32'h0000_0000);
        host.frame(32'h0000_0500, 15);
        rd(OFS_FAULT, 32'h0000_0002);
        host.frame(32'h0000_0500, 16);
        rd(OFS_FAULT, 32'h0000_0002);
        host.frame(32'h0000_0500, 16);
        rd(OFS_FAULT, 32'h0000_0000);
        host.frame(32'h0000_0000, 0);
        rd(OFS_FAULT, 32'h0000_0002);
        host.frame(32'h0000_0500, 16);
        host.frame(32'h0000_0500, 16);
        rd(OFS_FAULT, 32'h0000_0000);
        host.frame({16'h8312, 8'h00, crc8(16'h8312) ^ 8'h01}, 32);
        rd(OFS_FAULT, 32'h0000_0002);
        host.frame({16'h8312, 8'h00, crc8(16'h8312)}, 32);
        host.frame(32'h0000_0500, 16);
        rd(OFS_FAULT, 32'h0000_0000);
        give_verdict();
    end
    initial begin
        #2_000_000;
        mismatches++;
        give_verdict();
    end
endmodule
bind pfs_flags pfs_flags_asserts #(.NUM_RAILS(NUM_RAILS)) u_chk (.clk_sys_in, .rstn_in,
    .reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rd_in, .reg_rdata_out, .link_sclk_in,
    .link_cs_n_in, .link_mosi_in, .ilimit_active_in, .rail_ov_in, .rail_uv_in,
    .shoot_through_in, .fault_flags_out, .irq_out);
